// [cpu8_opcode_decode_timing.sv]
// instruction decode and timing block with an axi4-lite register port
`timescale 1ns/1ns
`default_nettype none
// Behaviour
// RULE1 - multiply index by accumulator, eleven cycles
// RULE2 - multiply clears half carry and carry
// RULE3 - upper nibble selects six addressing modes
// RULE4 - lower nibble selects register/memory operation
// RULE5 - load and alu cycles per mode
// RULE6 - store, jump, call: no immediate form
// RULE7 - bit test sets flags, accumulator kept
// RULE8 - branches two bytes, three cycles
// RULE9 - opcodes 22 and 23 unsigned compare
// RULE10 - 24 and 25 shared with higher-same, lower
// RULE11 - 28 and 29 test half carry
// RULE12 - 2C and 2D test interrupt mask
// RULE13 - 2E and 2F test interrupt pin
// RULE14 - taken branch adds signed offset
module cpu8_opcode_decode_timing import cpu8_pkg::*; (
	input wire logic clk,
	input wire logic reset,
	input wire logic ce,
	input wire logic irq_pin,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic busy
);
	typedef enum logic {ST_IDLE, ST_EXEC} state_e;

	// true for any register offset
	function automatic logic mapped(input logic [7:0] a);
		return a[1:0] == 2'h0 && a <= OFS_RETURN;
	endfunction

	// byte lane merge under write strobes
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
			input logic [3:0] strb);
		logic [31:0] r;
		for (int i = 0; i < 4; i++) begin
			r[i*8 +: 8] = strb[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
		end
		return r;
	endfunction

	// bus state
	logic aw_held, next_aw_held; // address waiting for data
	logic [7:0] aw_addr, next_aw_addr;
	logic w_held, next_w_held; // data waiting for address
	logic [31:0] w_data, next_w_data;
	logic [3:0] w_strb, next_w_strb;
	logic [1:0] bresp, next_bresp;
	logic bvalid, next_bvalid;
	logic [31:0] rdata, next_rdata;
	logic [1:0] rresp, next_rresp;
	logic rvalid, next_rvalid;
	// write decode
	logic aw_take, w_take, wr_fire;
	logic [7:0] wr_addr;
	logic [31:0] wr_data;
	logic [3:0] wr_strb;
	logic [31:0] rd_word; // read mux
	logic [31:0] instr_merged, pc_merged; // strobe merged words for wide registers
	// architectural state
	state_e state, next_state;
	logic [3:0] count, next_count; // cycles left
	logic [23:0] instr, next_instr; // opcode, then two operand bytes
	logic [7:0] operand, next_operand; // memory byte fetched for the op
	logic [7:0] acc, next_acc;
	logic [7:0] idx, next_idx;
	logic [4:0] flags, next_flags;
	logic [15:0] pc, next_pc;
	logic [7:0] store_data, next_store_data; // byte a store writes
	logic [15:0] ret_addr, next_ret_addr; // return address of calls
	logic illegal, next_illegal;
	logic taken, next_taken; // last branch went
	// irq synchroniser
	logic irq_s1, irq_s2, irq_s3, irq_level, next_irq_level;
	// decode and datapath
	cls_e dec_cls;
	logic [2:0] dec_mode;
	logic [1:0] dec_bytes;
	logic [3:0] dec_cycles;
	logic [7:0] opc, op1, op2;
	logic [7:0] mem_byte;
	logic [7:0] alu_acc, alu_idx;
	logic [4:0] alu_flags;
	logic [15:0] pc_seq, ea, rel_target;
	logic [15:0] product;
	logic start_req, commit, cond;

	assign opc = instr[7:0];
	assign op1 = instr[15:8];
	assign op2 = instr[23:16];

	opcode_decode opcode_decode_inst (
		.opcode(opc),
		.cls(dec_cls),
		.mode(dec_mode),
		.bytes(dec_bytes),
		.cycles(dec_cycles)
	);

	// immediate operand comes from the instruction itself
	assign mem_byte = (dec_mode == MODE_IMM) ? op1 : operand;

	alu8 alu8_inst (
		.op(opc[3:0]),
		.acc(acc),
		.idx(idx),
		.mem(mem_byte),
		.flags(flags),
		.acc_out(alu_acc),
		.idx_out(alu_idx),
		.flags_out(alu_flags)
	);

	// bus handshakes, all frozen while ce is low
	assign s_axi_awready = ce & ~aw_held & ~bvalid;
	assign s_axi_wready = ce & ~w_held & ~bvalid;
	assign s_axi_arready = ce & ~rvalid;
	assign s_axi_bresp = bresp;
	assign s_axi_bvalid = bvalid;
	assign s_axi_rdata = rdata;
	assign s_axi_rresp = rresp;
	assign s_axi_rvalid = rvalid;
	assign busy = (state == ST_EXEC);

	assign aw_take = s_axi_awvalid & s_axi_awready;
	assign w_take = s_axi_wvalid & s_axi_wready;
	assign wr_fire = (aw_held | aw_take) & (w_held | w_take);
	assign wr_addr = aw_held ? aw_addr : s_axi_awaddr;
	assign wr_data = w_held ? w_data : s_axi_wdata;
	assign wr_strb = w_held ? w_strb : s_axi_wstrb;
	// a call result cannot be part-selected, so merge into named words first
	assign instr_merged = merge({8'h00, instr}, wr_data, wr_strb);
	assign pc_merged = merge({16'h0000, pc}, wr_data, wr_strb);

	// read mux
	always_comb begin
		rd_word = 32'h0000_0000;
		unique case (s_axi_araddr)
			OFS_INSTR: rd_word = {8'h00, instr};
			OFS_OPERAND: rd_word = {24'h00_0000, operand};
			OFS_ACC: rd_word = {24'h00_0000, acc};
			OFS_IDX: rd_word = {24'h00_0000, idx};
			OFS_FLAGS: rd_word = {27'h000_0000, flags};
			OFS_PC: rd_word = {16'h0000, pc};
			OFS_STATUS: rd_word = {23'h00_0000, taken, dec_cycles, dec_bytes, illegal, busy};
			OFS_STORE: rd_word = {24'h00_0000, store_data};
			OFS_RETURN: rd_word = {16'h0000, ret_addr};
			default: rd_word = 32'h0000_0000; // ctrl and holes read zero
		endcase
	end

	// bus next state
	always_comb begin
		next_aw_held = aw_held;
		next_aw_addr = aw_addr;
		next_w_held = w_held;
		next_w_data = w_data;
		next_w_strb = w_strb;
		next_bresp = bresp;
		next_bvalid = bvalid;
		next_rdata = rdata;
		next_rresp = rresp;
		next_rvalid = rvalid;
		if (wr_fire) begin
			next_aw_held = 1'b0;
			next_w_held = 1'b0;
			next_bvalid = 1'b1;
			next_bresp = mapped(wr_addr) ? RESP_OKAY : RESP_SLVERR;
		end else begin
			if (aw_take) begin
				next_aw_held = 1'b1;
				next_aw_addr = s_axi_awaddr;
			end
			if (w_take) begin
				next_w_held = 1'b1;
				next_w_data = s_axi_wdata;
				next_w_strb = s_axi_wstrb;
			end
		end
		if (bvalid && s_axi_bready) begin
			next_bvalid = 1'b0;
		end
		if (s_axi_arvalid && s_axi_arready) begin
			next_rvalid = 1'b1;
			next_rdata = rd_word;
			next_rresp = mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
		end else if (rvalid && s_axi_rready) begin
			next_rvalid = 1'b0;
		end
	end

	// bus registers
	always_ff @(posedge clk) begin
		if (reset) begin
			aw_held <= 1'b0;
			aw_addr <= RST_BYTE;
			w_held <= 1'b0;
			w_data <= 32'h0000_0000;
			w_strb <= 4'h0;
			bresp <= RESP_OKAY;
			bvalid <= 1'b0;
			rdata <= 32'h0000_0000;
			rresp <= RESP_OKAY;
			rvalid <= 1'b0;
		end else if (ce) begin
			aw_held <= next_aw_held;
			aw_addr <= next_aw_addr;
			w_held <= next_w_held;
			w_data <= next_w_data;
			w_strb <= next_w_strb;
			bresp <= next_bresp;
			bvalid <= next_bvalid;
			rdata <= next_rdata;
			rresp <= next_rresp;
			rvalid <= next_rvalid;
		end
	end

	// pin level accepted once second and third stages agree
	always_comb begin
		next_irq_level = (irq_s2 == irq_s3) ? irq_s3 : irq_level;
	end

	// irq synchroniser registers
	always_ff @(posedge clk) begin
		if (reset) begin
			irq_s1 <= 1'b0;
			irq_s2 <= 1'b0;
			irq_s3 <= 1'b0;
			irq_level <= 1'b0;
		end else if (ce) begin
			irq_s1 <= irq_pin;
			irq_s2 <= irq_s1;
			irq_s3 <= irq_s2;
			irq_level <= next_irq_level;
		end
	end

	// start strobe is bit 0 of ctrl, honoured only when idle
	assign start_req = wr_fire && wr_addr == OFS_CTRL && wr_strb[0] && wr_data[0]
		&& state == ST_IDLE;
	assign commit = (state == ST_EXEC) && (count == 4'h1);
	assign pc_seq = pc + {14'h0000, dec_bytes};
	assign rel_target = pc_seq + {{8{op1[7]}}, op1}; // RULE14
	assign product = {8'h00, idx} * {8'h00, acc}; // RULE1

	// effective address per mode
	always_comb begin
		unique case (dec_mode)
			MODE_DIR: ea = {8'h00, op1};
			MODE_EXT, MODE_IMM: ea = {op1, op2};
			MODE_IX: ea = {8'h00, idx};
			MODE_IX1: ea = {8'h00, op1} + {8'h00, idx};
			default: ea = {op1, op2} + {8'h00, idx};
		endcase
	end

	// branch condition, low bit inverts the test
	always_comb begin
		unique case (opc[3:1])
			3'h0: cond = 1'b1;
			3'h1: cond = ~(flags[FLAG_C] | flags[FLAG_Z]); // RULE9
			3'h2: cond = ~flags[FLAG_C]; // RULE10
			3'h3: cond = ~flags[FLAG_Z];
			3'h4: cond = ~flags[FLAG_H]; // RULE11
			3'h5: cond = ~flags[FLAG_N];
			3'h6: cond = ~flags[FLAG_I]; // RULE12
			default: cond = ~irq_level; // RULE13
		endcase
		cond = cond ^ opc[0];
	end

	// architectural next state
	always_comb begin
		next_state = state;
		next_count = count;
		next_instr = instr;
		next_operand = operand;
		next_acc = acc;
		next_idx = idx;
		next_flags = flags;
		next_pc = pc;
		next_store_data = store_data;
		next_ret_addr = ret_addr;
		next_illegal = illegal;
		next_taken = taken;
		// software writes only land while idle
		if (wr_fire && state == ST_IDLE) begin
			unique case (wr_addr)
				OFS_INSTR: next_instr = instr_merged[23:0];
				OFS_OPERAND: next_operand = wr_strb[0] ? wr_data[7:0] : operand;
				OFS_ACC: next_acc = wr_strb[0] ? wr_data[7:0] : acc;
				OFS_IDX: next_idx = wr_strb[0] ? wr_data[7:0] : idx;
				OFS_FLAGS: next_flags = wr_strb[0] ? wr_data[4:0] : flags;
				OFS_PC: next_pc = pc_merged[15:0];
				default: next_state = state;
			endcase
		end
		unique case (state)
			ST_IDLE: begin
				if (start_req) begin
					next_illegal = (dec_cls == CLS_ILLEGAL);
					if (dec_cls != CLS_ILLEGAL) begin
						next_state = ST_EXEC;
						next_count = dec_cycles; // RULE5
					end
				end
			end
			ST_EXEC: begin
				next_count = count - 4'h1;
				if (commit) begin
					next_state = ST_IDLE;
					next_pc = pc_seq;
					unique case (dec_cls)
						CLS_PRODUCT: begin
							next_idx = product[15:8]; // RULE1
							next_acc = product[7:0];
							next_flags[FLAG_H] = 1'b0; // RULE2
							next_flags[FLAG_C] = 1'b0;
						end
						CLS_BRANCH: begin
							next_taken = cond;
							if (cond) begin
								next_pc = rel_target; // RULE14
							end
						end
						CLS_RELCALL: begin
							next_ret_addr = pc_seq;
							next_pc = rel_target; // RULE14
						end
						default: begin
							unique case (opc[3:0])
								LO_STORE_ACC, LO_STORE_INDEX: begin
									next_store_data = opc[3] ? idx : acc; // RULE4
									next_flags[FLAG_N] = next_store_data[7];
									next_flags[FLAG_Z] = (next_store_data == 8'h00);
								end
								LO_JUMP: next_pc = ea; // RULE4
								LO_CALL: begin
									next_ret_addr = pc_seq;
									next_pc = ea;
								end
								default: begin
									next_acc = alu_acc; // RULE7
									next_idx = alu_idx;
									next_flags = alu_flags;
								end
							endcase
						end
					endcase
				end
			end
		endcase
	end

	// architectural registers
	always_ff @(posedge clk) begin
		if (reset) begin
			state <= ST_IDLE;
			count <= 4'h0;
			instr <= 24'h00_0000;
			operand <= RST_BYTE;
			acc <= RST_BYTE;
			idx <= RST_BYTE;
			flags <= RST_FLAGS;
			pc <= RST_PC;
			store_data <= RST_BYTE;
			ret_addr <= RST_PC;
			illegal <= 1'b0;
			taken <= 1'b0;
		end else if (ce) begin
			state <= next_state;
			count <= next_count;
			instr <= next_instr;
			operand <= next_operand;
			acc <= next_acc;
			idx <= next_idx;
			flags <= next_flags;
			pc <= next_pc;
			store_data <= next_store_data;
			ret_addr <= next_ret_addr;
			illegal <= next_illegal;
			taken <= next_taken;
		end
	end

	default clocking @(posedge clk); endclocking
	default disable iff (reset);

	chk_mul_cycles: assert property (ce && start_req && opc == OP_PRODUCT // RULE1
		|=> state == ST_EXEC && count == 4'hB) else $error("multiply not 11 cycles");
	chk_mul_result: assert property (ce && commit && dec_cls == CLS_PRODUCT // RULE1
		|=> {idx, acc} == $past(idx) * $past(acc)) else $error("bad product");
	chk_mul_flags: assert property (ce && commit && dec_cls == CLS_PRODUCT // RULE2
		|=> !flags[FLAG_H] && !flags[FLAG_C] && flags[FLAG_Z] == $past(flags[FLAG_Z]))
		else $error("multiply flags wrong");
	chk_mode_bytes: assert property (dec_cls == CLS_MEMOP && opc[7:4] == 4'hF // RULE3
		|-> dec_bytes == 2'h1) else $error("no offset length wrong");
	chk_load_index: assert property (opc == 8'hDE // RULE4
		|-> dec_cls == CLS_MEMOP && dec_cycles == 4'h5) else $error("load index decode");
	chk_store_cycles: assert property (dec_cls == CLS_MEMOP && opc == 8'hB7 // RULE6
		|-> dec_cycles == 4'h4 && dec_bytes == 2'h2) else $error("store timing");
	chk_bit_keeps: assert property (ce && commit && dec_cls == CLS_MEMOP // RULE7
		&& opc[3:0] == LO_BIT_TEST |=> acc == $past(acc)) else $error("bit test changed a");
	chk_branch_len: assert property (dec_cls == CLS_BRANCH // RULE8
		|-> dec_bytes == 2'h2 && dec_cycles == 4'h3) else $error("branch timing");
	chk_branch_miss: assert property (ce && commit && dec_cls == CLS_BRANCH && !cond // RULE14
		|=> pc == $past(pc) + 16'h0002) else $error("not taken pc wrong");
endmodule
`default_nettype wire

// [cpu8_pkg.sv]
// constants and types shared by the opcode decode and timing block
package cpu8_pkg;
	// register byte offsets on the bus
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_INSTR = 8'h04;
	localparam logic [7:0] OFS_OPERAND = 8'h08;
	localparam logic [7:0] OFS_ACC = 8'h0C;
	localparam logic [7:0] OFS_IDX = 8'h10;
	localparam logic [7:0] OFS_FLAGS = 8'h14;
	localparam logic [7:0] OFS_PC = 8'h18;
	localparam logic [7:0] OFS_STATUS = 8'h1C;
	localparam logic [7:0] OFS_STORE = 8'h20;
	localparam logic [7:0] OFS_RETURN = 8'h24;
	// reset values
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [4:0] RST_FLAGS = 5'h08;
	localparam logic [15:0] RST_PC = 16'h0000;
	// axi responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// flag bit positions
	localparam int FLAG_H = 4;
	localparam int FLAG_I = 3;
	localparam int FLAG_N = 2;
	localparam int FLAG_Z = 1;
	localparam int FLAG_C = 0;
	// special opcodes and nibbles
	localparam logic [7:0] OP_PRODUCT = 8'h42;
	localparam logic [7:0] OP_RELATIVE_CALL = 8'hAD;
	localparam logic [3:0] NIB_BRANCH = 4'h2;
	// register/memory lower nibbles
	localparam logic [3:0] LO_MINUS = 4'h0;
	localparam logic [3:0] LO_COMPARE_ACC = 4'h1;
	localparam logic [3:0] LO_DIFF_BORROW = 4'h2;
	localparam logic [3:0] LO_COMPARE_INDEX = 4'h3;
	localparam logic [3:0] LO_AND = 4'h4;
	localparam logic [3:0] LO_BIT_TEST = 4'h5;
	localparam logic [3:0] LO_LOAD_ACC = 4'h6;
	localparam logic [3:0] LO_STORE_ACC = 4'h7;
	localparam logic [3:0] LO_XOR = 4'h8;
	localparam logic [3:0] LO_SUM_CARRY = 4'h9;
	localparam logic [3:0] LO_OR = 4'hA;
	localparam logic [3:0] LO_ADD = 4'hB;
	localparam logic [3:0] LO_JUMP = 4'hC;
	localparam logic [3:0] LO_CALL = 4'hD;
	localparam logic [3:0] LO_LOAD_INDEX = 4'hE;
	localparam logic [3:0] LO_STORE_INDEX = 4'hF;
	// addressing modes, also table indexes
	localparam logic [2:0] MODE_IMM = 3'h0;
	localparam logic [2:0] MODE_DIR = 3'h1;
	localparam logic [2:0] MODE_EXT = 3'h2;
	localparam logic [2:0] MODE_IX = 3'h3;
	localparam logic [2:0] MODE_IX1 = 3'h4;
	localparam logic [2:0] MODE_IX2 = 3'h5;
	// per mode tables, immediate in the low field
	localparam logic [11:0] BYTES_MODE = {2'h3, 2'h2, 2'h1, 2'h3, 2'h2, 2'h2};
	localparam logic [23:0] CYC_DATA = {4'h5, 4'h4, 4'h3, 4'h4, 4'h3, 4'h2};
	localparam logic [23:0] CYC_STORE = {4'h6, 4'h5, 4'h4, 4'h5, 4'h4, 4'h0};
	localparam logic [23:0] CYC_JUMP = {4'h4, 4'h3, 4'h2, 4'h3, 4'h2, 4'h0};
	localparam logic [23:0] CYC_CALL = {4'h7, 4'h6, 4'h5, 4'h6, 4'h5, 4'h0};
	localparam logic [1:0] BYTES_BRANCH = 2'h2;
	localparam logic [3:0] CYC_BRANCH = 4'h3;
	localparam logic [3:0] CYC_RELATIVE_CALL = 4'h6;
	localparam logic [1:0] BYTES_PRODUCT = 2'h1;
	localparam logic [3:0] CYC_PRODUCT = 4'hB;
	// instruction classes
	typedef enum logic [2:0] {
		CLS_ILLEGAL, CLS_MEMOP, CLS_BRANCH, CLS_RELCALL, CLS_PRODUCT
	} cls_e;
endpackage

// [opcode_decode.sv]
// opcode to class, mode, length and cycle count
`timescale 1ns/1ns
`default_nettype none
module opcode_decode import cpu8_pkg::*; (
	input wire logic [7:0] opcode,
	output cls_e cls,
	output logic [2:0] mode,
	output logic [1:0] bytes,
	output logic [3:0] cycles
);
	logic [3:0] hi; // mode nibble
	logic [3:0] lo; // operation nibble
	assign hi = opcode[7:4];
	assign lo = opcode[3:0];

	// classify and time one opcode
	always_comb begin
		cls = CLS_ILLEGAL;
		bytes = 2'h0;
		cycles = 4'h0;
		unique case (hi)
			4'hA: mode = MODE_IMM;
			4'hB: mode = MODE_DIR;
			4'hC: mode = MODE_EXT;
			4'hF: mode = MODE_IX;
			4'hE: mode = MODE_IX1;
			default: mode = MODE_IX2;
		endcase
		if (opcode == OP_PRODUCT) begin
			cls = CLS_PRODUCT; // RULE1
			bytes = BYTES_PRODUCT;
			cycles = CYC_PRODUCT;
		end else if (hi == NIB_BRANCH) begin
			cls = CLS_BRANCH; // RULE8
			bytes = BYTES_BRANCH;
			cycles = CYC_BRANCH;
		end else if (opcode == OP_RELATIVE_CALL) begin
			cls = CLS_RELCALL; // RULE8
			bytes = BYTES_BRANCH;
			cycles = CYC_RELATIVE_CALL;
		end else if (hi >= 4'hA) begin
			// no immediate form for stores and jumps
			if (!(mode == MODE_IMM && (lo == LO_STORE_ACC || lo == LO_STORE_INDEX
					|| lo == LO_JUMP))) begin // RULE6
				cls = CLS_MEMOP; // RULE3 RULE4
				bytes = BYTES_MODE[{mode, 1'b0} +: 2]; // RULE3
				if (lo == LO_STORE_ACC || lo == LO_STORE_INDEX) begin
					cycles = CYC_STORE[{mode, 2'b00} +: 4]; // RULE6
				end else if (lo == LO_JUMP) begin
					cycles = CYC_JUMP[{mode, 2'b00} +: 4]; // RULE6
				end else if (lo == LO_CALL) begin
					cycles = CYC_CALL[{mode, 2'b00} +: 4]; // RULE6
				end else begin
					cycles = CYC_DATA[{mode, 2'b00} +: 4]; // RULE5
				end
			end
		end
	end
endmodule
`default_nettype wire

// [alu8.sv]
// data path for the register/memory operations
`timescale 1ns/1ns
`default_nettype none
module alu8 import cpu8_pkg::*; (
	input wire logic [3:0] op,
	input wire logic [7:0] acc,
	input wire logic [7:0] idx,
	input wire logic [7:0] mem,
	input wire logic [4:0] flags,
	output logic [7:0] acc_out,
	output logic [7:0] idx_out,
	output logic [4:0] flags_out
);
	logic [8:0] sum; // nine bits keep the carry
	logic [8:0] diff; // nine bits keep the borrow
	logic [4:0] half; // low nibble sum for half carry
	logic [7:0] res; // result for n and z
	logic cin; // carry used by the carry forms

	// compute result and flags
	always_comb begin
		cin = (op == LO_SUM_CARRY || op == LO_DIFF_BORROW) ? flags[FLAG_C] : 1'b0;
		sum = {1'b0, acc} + {1'b0, mem} + {8'h00, cin};
		half = {1'b0, acc[3:0]} + {1'b0, mem[3:0]} + {4'h0, cin};
		diff = {1'b0, (op == LO_COMPARE_INDEX) ? idx : acc} - {1'b0, mem} - {8'h00, cin};
		acc_out = acc;
		idx_out = idx;
		flags_out = flags;
		unique case (op)
			LO_ADD, LO_SUM_CARRY: begin
				res = sum[7:0];
				acc_out = res;
				flags_out[FLAG_H] = half[4];
				flags_out[FLAG_C] = sum[8];
			end
			LO_MINUS, LO_DIFF_BORROW: begin
				res = diff[7:0];
				acc_out = res;
				flags_out[FLAG_C] = diff[8];
			end
			LO_COMPARE_ACC, LO_COMPARE_INDEX: begin
				res = diff[7:0]; // flags only
				flags_out[FLAG_C] = diff[8];
			end
			LO_AND: begin
				res = acc & mem;
				acc_out = res;
			end
			LO_BIT_TEST: res = acc & mem; // RULE7
			LO_OR: begin
				res = acc | mem;
				acc_out = res;
			end
			LO_XOR: begin
				res = acc ^ mem;
				acc_out = res;
			end
			LO_LOAD_ACC: begin
				res = mem;
				acc_out = res;
			end
			LO_LOAD_INDEX: begin
				res = mem;
				idx_out = res;
			end
			default: res = acc; // stores, jumps and calls
		endcase
		flags_out[FLAG_N] = res[7];
		flags_out[FLAG_Z] = (res == 8'h00);
	end
endmodule
`default_nettype wire

// [prog_mem.sv]
// program memory model handing out instruction bytes by address
`timescale 1ns/1ns
`default_nettype none
module prog_mem (
	input wire logic [15:0] addr,
	output logic [7:0] data
);
	// scrambled contents so that neighbouring bytes differ, except at 7FFF/8000 and FFFF/0000
	assign data = addr[7:0] ^ {addr[12:8], addr[15:13]} ^ 8'h5A;
endmodule
`default_nettype wire

// [cpu8_opcode_decode_timing_test.sv]
// self-checking bench for the decode and timing block
`timescale 1ns/1ns
`default_nettype none
module cpu8_opcode_decode_timing_test import cpu8_pkg::*;;
	typedef struct packed {logic [7:0] a; logic [33:0] m; logic [33:0] v;} note_s;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic irq_pin = 1'b0;
	logic [7:0] awaddr = 8'h00;
	logic [7:0] araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic awvalid = 1'b0;
	logic wvalid = 1'b0;
	logic bready = 1'b0;
	logic arvalid = 1'b0;
	logic rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid, busy;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	logic [15:0] fetch_addr = 16'h0000;
	logic [7:0] fetch_byte;
	int mismatches = 0;
	int compares = 0;
	note_s notes[$]; // expected read answers
	int lens[$]; // expected busy lengths
	logic [1:0] wexp[$]; // expected write responses
	int run_len = 0;
	logic busy_q = 1'b0;
	logic [31:0] seed = 32'h24;
	// mode tables: imm, dir, ext, ix, ix1, ix2
	logic [3:0] up [6] = '{4'hA, 4'hB, 4'hC, 4'hF, 4'hE, 4'hD};
	int cd [6] = '{2, 3, 4, 3, 4, 5};
	int cs [6] = '{0, 4, 5, 4, 5, 6};
	int cj [6] = '{0, 2, 3, 2, 3, 4};
	int cc [6] = '{0, 5, 6, 5, 6, 7};
	logic [15:0] nb [6] = '{16'h2, 16'h2, 16'h3, 16'h1, 16'h2, 16'h3};
	logic [3:0] dn [12] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h8, 4'h9, 4'hA, 4'hB, 4'hE};

	cpu8_opcode_decode_timing cpu8_opcode_decode_timing_inst (
		.clk(clk), .reset(reset), .ce(1'b1), .irq_pin(irq_pin),
		.s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .busy(busy)
	);
	prog_mem prog_mem_inst (.addr(fetch_addr), .data(fetch_byte));

	// free running clock
	initial begin
		forever #4 clk = ~clk;
	end

	// xorshift byte source
	function automatic logic [7:0] rb();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed[7:0];
	endfunction

	// one write, address and data taken in either order
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
			input logic [1:0] r = RESP_OKAY);
		logic aw, w;
		wexp.push_back(r);
		aw = 1'b1;
		w = 1'b1;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (aw || w) begin
			@(posedge clk);
			if (aw && awready === 1'b1) begin
				aw = 1'b0;
				awvalid <= 1'b0;
			end
			if (w && wready === 1'b1) begin
				w = 1'b0;
				wvalid <= 1'b0;
			end
		end
		do @(posedge clk); while (bvalid !== 1'b1);
		bready <= 1'b0;
		// let an edge pass so a following write does not reassign bready
		@(posedge clk);
	endtask

	// one read, expected answer noted for the monitor
	task automatic rd(input logic [7:0] a, input logic [33:0] v, input logic [33:0] m);
		notes.push_back('{a, m, v});
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge clk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge clk); while (rvalid !== 1'b1);
		rready <= 1'b0;
		// let an edge pass so a following read does not reassign rready
		@(posedge clk);
	endtask

	task automatic rdw(input logic [7:0] a, input logic [31:0] d);
		rd(a, {RESP_OKAY, d}, {34{1'b1}});
	endtask

	// start one instruction and wait for it to finish
	task automatic run(input logic [23:0] ins, input int n);
		int i;
		wr(OFS_INSTR, {8'h00, ins});
		lens.push_back(n);
		wr(OFS_CTRL, 32'h1);
		for (i = 0; i < 40 && busy === 1'b1; i++) @(posedge clk);
	endtask

	// opcode that must be refused as illegal
	task automatic bad(input logic [7:0] op);
		wr(OFS_INSTR, {24'h0, op});
		wr(OFS_CTRL, 32'h1);
		rd(OFS_STATUS, 34'h2, 34'h3);
	endtask

	task automatic complete_run();
		if (lens.size() != 0 || notes.size() != 0 || wexp.size() != 0) mismatches++;
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask

	// read answer monitor
	always @(posedge clk) begin
		note_s n;
		logic [1:0] r;
		if (rvalid === 1'b1 && rready === 1'b1) begin
			n = notes.pop_front();
			compares++;
			if ((({rresp, rdata} ^ n.v) & n.m) !== 34'h0) begin
				mismatches++;
				$display("mismatch reg %h expected %h seen %h", n.a, n.v, {rresp, rdata});
			end
		end
		// write response answer
		if (bvalid === 1'b1 && bready === 1'b1) begin
			r = wexp.pop_front();
			compares++;
			if (bresp !== r) begin
				mismatches++;
				$display("mismatch bresp expected %h seen %h", r, bresp);
			end
		end
	end

	// busy length monitor
	always @(posedge clk) begin
		int e;
		busy_q <= busy;
		run_len <= (busy === 1'b1) ? run_len + 1 : 0;
		if (busy_q === 1'b1 && busy === 1'b0) begin
			e = lens.pop_front();
			compares++;
			if (run_len != e) begin
				mismatches++;
				$display("mismatch busy cycles expected %0d seen %0d", e, run_len);
			end
		end
	end

	// watchdog
	initial begin
		repeat (30000) @(posedge clk);
		mismatches++;
		complete_run();
	end

	initial begin
		int i, k, t;
		logic [7:0] u, v, m, a, o, op, b8;
		logic [15:0] p, e, pr;
		repeat (8) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		rd(8'h28, {RESP_SLVERR, 32'h0}, {2'h3, 32'h0});
		wr(8'h02, 32'h0, RESP_SLVERR);
		$display("test bus done");
		// multiply, first pass at the largest operands
		for (k = 0; k < 3; k++) begin
			a = (k == 0) ? 8'hFF : rb();
			u = (k == 0) ? 8'hFF : rb();
			pr = a * u;
			wr(OFS_ACC, {24'h0, a});
			wr(OFS_IDX, {24'h0, u});
			wr(OFS_FLAGS, 32'h1F);
			run({16'h0, OP_PRODUCT}, 11);
			rdw(OFS_ACC, {24'h0, pr[7:0]});
			rdw(OFS_IDX, {24'h0, pr[15:8]});
			rdw(OFS_FLAGS, 32'h0E);
		end
		$display("test product done");
		// every addressing mode of the register/memory group
		for (i = 0; i < 6; i++) begin
			u = rb();
			v = rb();
			a = rb();
			m = (i == 0) ? u : v;
			wr(OFS_OPERAND, {24'h0, v});
			for (k = 0; k < 12; k++) run({8'h0, u, up[i], dn[k]}, cd[i]);
			wr(OFS_ACC, {24'h0, a});
			run({8'h0, u, up[i], LO_BIT_TEST}, cd[i]);
			rdw(OFS_ACC, {24'h0, a});
			run({8'h0, u, up[i], LO_AND}, cd[i]);
			rdw(OFS_ACC, {24'h0, a & m});
			run({8'h0, u, up[i], LO_LOAD_INDEX}, cd[i]);
			rdw(OFS_IDX, {24'h0, m});
			if (i == 0) begin
				bad(8'hA7);
				bad(8'hAF);
				bad(8'hAC);
			end else begin
				run({8'h0, u, up[i], LO_STORE_ACC}, cs[i]);
				rdw(OFS_STORE, {24'h0, a & m});
				run({8'h0, u, up[i], LO_STORE_INDEX}, cs[i]);
				rdw(OFS_STORE, {24'h0, m});
				run({8'h0, u, up[i], LO_JUMP}, cj[i]);
				// effective address: byte1 is u, byte2 zero, index holds m
				case (i)
					1: e = {8'h0, u};
					2: e = {u, 8'h0};
					3: e = {8'h0, m};
					4: e = {8'h0, u} + m;
					default: e = {u, 8'h0} + m;
				endcase
				rdw(OFS_PC, {16'h0, e});
				run({8'h0, u, up[i], LO_CALL}, cc[i]);
				rdw(OFS_PC, {16'h0, e});
				rdw(OFS_RETURN, {16'h0, e + nb[i]});
			end
		end
		$display("test modes done");
		// all relative branches with random flags, pin and offset
		for (k = 0; k < 48; k++) begin
			op = {4'h2, k[3:0]};
			b8 = rb();
			p = {rb(), rb()};
			irq_pin <= b8[7];
			wr(OFS_FLAGS, {27'h0, b8[4:0]});
			wr(OFS_PC, {16'h0, p});
			fetch_addr <= p + 16'h1;
			@(posedge clk);
			o = fetch_byte;
			case (op[3:1])
				3'h0: t = 1;
				3'h1: t = !(b8[FLAG_C] | b8[FLAG_Z]);
				3'h2: t = !b8[FLAG_C];
				3'h3: t = !b8[FLAG_Z];
				3'h4: t = !b8[FLAG_H];
				3'h5: t = !b8[FLAG_N];
				3'h6: t = !b8[FLAG_I];
				default: t = !b8[7];
			endcase
			t = t ^ op[0];
			e = p + 16'h2 + ((t != 0) ? {{8{o[7]}}, o} : 16'h0);
			run({8'h0, o, op}, 3);
			rdw(OFS_PC, {16'h0, e});
			if (k < 8) begin
				wr(OFS_PC, {16'h0, p});
				run({8'h0, o, OP_RELATIVE_CALL}, 6);
				rdw(OFS_PC, {16'h0, p + 16'h2 + {{8{o[7]}}, o}});
				rdw(OFS_RETURN, {16'h0, p + 16'h2});
			end
		end
		$display("test branches done");
		complete_run();
	end
endmodule
`default_nettype wire
